// ### bsr_defines.svh
`ifndef BSR_DEFINES_SVH
`define BSR_DEFINES_SVH

`define BSR_CLK_MHZ          200
`define BSR_STORE_NS         8000
`define BSR_RESTORE_NS       2000
`define BSR_STORE_CYC        ((`BSR_STORE_NS * `BSR_CLK_MHZ + 999) / 1000)
`define BSR_RESTORE_CYC      ((`BSR_RESTORE_NS * `BSR_CLK_MHZ + 999) / 1000)
`define BSR_CNT_W            16
`define BSR_ASD_RESET        1'h0
`define BSR_BUSY_BIT         0
`define BSR_ASD_BIT          6
`define BSR_PROT_LSB         2
`define BSR_ROLL_BIT         4

`endif

// ### bsr_pkg.sv
`default_nettype none
package bsr_pkg;
  typedef enum logic [2:0] {
    BSR_OFF,
    BSR_READY,
    BSR_STORE,
    BSR_RECALL,
    BSR_HIB_WAIT,
    BSR_HIB
  } bsr_state_t;

  typedef enum logic [1:0] {
    BSR_XF_NONE,
    BSR_XF_STORE,
    BSR_XF_RECALL
  } bsr_xfer_t;
endpackage : bsr_pkg
`default_nettype wire

// ### bsr_timer_if.sv
`default_nettype none
interface bsr_timer_if;
  logic        start;
  logic        abort;
  logic [15:0] length;
  logic        running;
  logic        done;
  modport ctrl  (output start, output abort, output length, input running, input done);
  modport timer (input start, input abort, input length, output running, output done);
endinterface : bsr_timer_if
`default_nettype wire

// ### bsr_cycle_timer.sv
`include "bsr_defines.svh"
`default_nettype none
module bsr_cycle_timer (
  // Clock and reset
  input  wire logic  clk_in,
  input  wire logic  rst_n_in,
  // Control
  bsr_timer_if.timer tif
);
  logic [`BSR_CNT_W-1:0] count;
  logic [`BSR_CNT_W-1:0] next_count;
  logic                  next_done;
  logic                  done_q;

  always_comb begin
    next_count = count;
    next_done  = 1'b0;
    if (tif.abort) begin
      next_count = '0;
    end else if (tif.start) begin
      next_count = tif.length;
    end else if (count != '0) begin
      next_count = count - 16'h0001;
      next_done  = (count == 16'h0001);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      count  <= '0;
      done_q <= 1'b0;
    end else begin
      count  <= next_count;
      done_q <= next_done;
    end
  end

  assign tif.running = (count != '0);
  assign tif.done    = done_q;
endmodule : bsr_cycle_timer
`default_nettype wire

// ### bsr_backup_ctrl.sv
// What this block does
// - Automatic_backup-disable bit resets to 0, keeping automatic store enabled.
// - Automatic store only when array modified since last store or recall.
// - Power-down in ready state with disable bit 0 and array modified starts store.
// - Automatic store blocks all access for full store duration.
// - Power-up during automatic store: finish store, skip recall.
// - Power-up from off or hibernate triggers automatic recall, regardless of disable bit.
// - Automatic recall accepts only the status-read command for the restore duration.
// - Power-down during recall aborts it, no automatic store follows.
// - Software store copies array, user space and config bits always.
// - Software recall restores array, user space and config bits always.
// - During software or hibernate store, or recall, only status-read command is accepted.
// - Busy flag reads 1 during transfer, 0 once ended.
// - Status read repeats current status on every clocked byte.
// - Hibernate: on chip select high, store if modified, then sleep.
// - Chip select low or power cycle wakes, restores, ready after restore.
// - Below trip threshold all commands ignored, no response.
// - Main supply stays disconnected until above backup and stores done.
`include "bsr_defines.svh"
`default_nettype none
module bsr_backup_ctrl
  import bsr_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // Supply monitor (asynchronous levels)
  input  wire logic       backup_above_trip_in,
  input  wire logic       main_above_backup_in,
  // SPI side
  input  wire logic       cs_n_in,
  input  wire logic       sck_in,
  // Decoded commands (same clock)
  input  wire logic       cmd_valid_in,
  input  wire logic       cmd_is_status_read_in,
  input  wire logic       cmd_sw_store_in,
  input  wire logic       cmd_sw_recall_in,
  input  wire logic       cmd_hibernate_in,
  input  wire logic       write_done_in,
  // Configuration written by status write
  input  wire logic       cfg_we_in,
  input  wire logic [1:0] cfg_block_protect_in,
  input  wire logic       cfg_rollover_in,
  input  wire logic       cfg_automatic_backup_disable_in,
  // Command gating and status
  output logic            cmd_accept_out,
  output logic            spi_respond_out,
  output logic [7:0]      status_byte_out,
  output logic            transfer_busy_flag_out,
  output logic            array_modified_out,
  output logic            automatic_backup_disable_bit_out,
  output logic [1:0]      block_protect_field_out,
  output logic            rollover_mode_bit_out,
  // Transfer strobes, supply switch, sleep flag and link clock edge
  output logic            store_pulse_out,
  output logic            recall_pulse_out,
  output logic            main_supply_connect_out,
  output logic            hibernating_out,
  output logic            sck_rise_out
);
  bsr_timer_if tif ();

  bsr_cycle_timer u_timer (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .tif      (tif)
  );

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic [1:0] trip_s;
  logic [1:0] main_s;
  logic [1:0] cs_s;
  logic [1:0] sck_s;
  logic       sck_d;
  logic       trip_d;
  logic       cs_d;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      trip_s <= 2'h0;
      main_s <= 2'h0;
      cs_s   <= 2'h3;
      sck_s  <= 2'h0;
      sck_d  <= 1'b0;
      trip_d <= 1'b0;
      cs_d   <= 1'b1;
    end else begin
      trip_s <= {trip_s[0], backup_above_trip_in};
      main_s <= {main_s[0], main_above_backup_in};
      cs_s   <= {cs_s[0], cs_n_in};
      sck_s  <= {sck_s[0], sck_in};
      sck_d  <= sck_s[1];
      trip_d <= trip_s[1];
      cs_d   <= cs_s[1];
    end
  end

  logic pwr_ok;
  logic pwr_up_ev;
  logic pwr_dn_ev;
  logic cs_rise;
  logic cs_fall;
  assign pwr_ok    = trip_s[1];
  assign pwr_up_ev = trip_s[1] & ~trip_d;
  assign pwr_dn_ev = ~trip_s[1] & trip_d;
  assign cs_rise   = cs_s[1] & ~cs_d;
  assign cs_fall   = ~cs_s[1] & cs_d;

  // ------------------------------------------------------------
  // Transfer state machine
  // ------------------------------------------------------------
  bsr_state_t state;
  bsr_state_t next_state;
  logic       auto_store;
  logic       next_auto_store;
  logic       hib_req;
  logic       next_hib_req;
  logic       modified;
  logic       next_modified;
  logic       asd;
  logic       next_asd;
  logic [1:0] prot;
  logic [1:0] next_prot;
  logic       roll;
  logic       next_roll;
  logic [3:0] saved_cfg;
  logic [3:0] next_saved_cfg;
  logic       main_conn;
  logic       next_main_conn;
  logic       st_p;
  logic       next_st_p;
  logic       rc_p;
  logic       next_rc_p;
  logic       busy;

  assign busy = tif.running;

  always_comb begin
    next_state      = state;
    next_auto_store = auto_store;
    next_hib_req    = hib_req;
    next_modified   = modified;
    next_asd        = asd;
    next_prot       = prot;
    next_roll       = roll;
    next_saved_cfg  = saved_cfg;
    next_main_conn  = main_conn;
    next_st_p       = 1'b0;
    next_rc_p       = 1'b0;
    tif.start       = 1'b0;
    tif.abort       = 1'b0;
    tif.length      = 16'(`BSR_STORE_CYC);

    if (write_done_in && state == BSR_READY) begin
      next_modified = 1'b1;
    end
    if (cfg_we_in && state == BSR_READY && !busy) begin
      next_prot = cfg_block_protect_in;
      next_roll = cfg_rollover_in;
      next_asd  = cfg_automatic_backup_disable_in;
    end

    case (state)
      BSR_OFF: begin
        if (pwr_up_ev) begin
          tif.start  = 1'b1;
          tif.length = 16'(`BSR_RESTORE_CYC);
          next_state = BSR_RECALL;
        end
      end
      BSR_READY: begin
        if (pwr_dn_ev) begin
          next_main_conn = 1'b0;
          if (!asd && modified) begin
            tif.start       = 1'b1;
            next_auto_store = 1'b1;
            next_state      = BSR_STORE;
          end else begin
            next_state = BSR_OFF;
          end
        end else if (cmd_valid_in && cmd_sw_store_in) begin
          tif.start       = 1'b1;
          next_auto_store = 1'b0;
          next_state      = BSR_STORE;
        end else if (cmd_valid_in && cmd_sw_recall_in) begin
          tif.start  = 1'b1;
          tif.length = 16'(`BSR_RESTORE_CYC);
          next_state = BSR_RECALL;
        end else if (cmd_valid_in && cmd_hibernate_in) begin
          next_state = BSR_HIB_WAIT;
        end
      end
      BSR_HIB_WAIT: begin
        if (cs_rise) begin
          if (modified) begin
            tif.start       = 1'b1;
            next_auto_store = 1'b0;
            next_hib_req    = 1'b1;
            next_state      = BSR_STORE;
          end else begin
            next_state = BSR_HIB;
          end
        end
      end
      BSR_HIB: begin
        if (cs_fall || pwr_up_ev) begin
          tif.start  = 1'b1;
          tif.length = 16'(`BSR_RESTORE_CYC);
          next_state = BSR_RECALL;
        end else if (pwr_dn_ev) begin
          next_main_conn = 1'b0;
          next_state     = BSR_OFF;
        end
      end
      BSR_STORE: begin
        if (pwr_dn_ev) begin
          next_main_conn = 1'b0;
        end
        if (tif.done) begin
          next_st_p       = 1'b1;
          next_saved_cfg  = {asd, roll, prot};
          next_modified   = 1'b0;
          next_hib_req    = 1'b0;
          next_auto_store = 1'b0;
          if (hib_req) begin
            next_state = BSR_HIB;
          end else if (pwr_ok) begin
            next_state = BSR_READY;
          end else begin
            next_state = BSR_OFF;
          end
        end
      end
      BSR_RECALL: begin
        if (pwr_dn_ev) begin
          tif.abort      = 1'b1;
          next_main_conn = 1'b0;
          next_state     = BSR_OFF;
        end else if (tif.done) begin
          next_rc_p     = 1'b1;
          next_modified = 1'b0;
          next_asd      = saved_cfg[3];
          next_roll     = saved_cfg[2];
          next_prot     = saved_cfg[1:0];
          next_state    = BSR_READY;
        end
      end
      default: next_state = BSR_OFF;
    endcase

    if (!main_conn && main_s[1] && !(state == BSR_STORE)) begin
      next_main_conn = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state      <= BSR_OFF;
      auto_store <= 1'b0;
      hib_req    <= 1'b0;
      modified   <= 1'b0;
      asd        <= `BSR_ASD_RESET;
      prot       <= 2'h0;
      roll       <= 1'b0;
      saved_cfg  <= 4'h0;
      main_conn  <= 1'b0;
      st_p       <= 1'b0;
      rc_p       <= 1'b0;
    end else begin
      state      <= next_state;
      auto_store <= next_auto_store;
      hib_req    <= next_hib_req;
      modified   <= next_modified;
      asd        <= next_asd;
      prot       <= next_prot;
      roll       <= next_roll;
      saved_cfg  <= next_saved_cfg;
      main_conn  <= next_main_conn;
      st_p       <= next_st_p;
      rc_p       <= next_rc_p;
    end
  end

  // ------------------------------------------------------------
  // Status and gating outputs
  // ------------------------------------------------------------
  logic [7:0] status_q;
  logic [7:0] next_status;

  always_comb begin
    next_status                = 8'h00;
    next_status[`BSR_BUSY_BIT] = busy;
    next_status[`BSR_PROT_LSB+:2] = prot;
    next_status[`BSR_ROLL_BIT]    = roll;
    next_status[`BSR_ASD_BIT]  = asd;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      status_q <= 8'h00;
    end else begin
      status_q <= next_status;
    end
  end

  logic responsive;
  assign responsive = pwr_ok && (state == BSR_READY || state == BSR_STORE ||
                      state == BSR_RECALL || state == BSR_HIB_WAIT) && !auto_store;

  assign cmd_accept_out = cmd_valid_in && responsive &&
                          (busy ? cmd_is_status_read_in : 1'b1);
  assign spi_respond_out           = responsive;
  assign status_byte_out           = status_q;
  assign transfer_busy_flag_out    = busy;
  assign array_modified_out        = modified;
  assign automatic_backup_disable_bit_out = asd;
  assign block_protect_field_out   = prot;
  assign rollover_mode_bit_out     = roll;
  assign store_pulse_out           = st_p;
  assign recall_pulse_out          = rc_p;
  assign main_supply_connect_out   = main_conn;
  assign hibernating_out           = (state == BSR_HIB);
  assign sck_rise_out              = sck_s[1] & ~sck_d;
endmodule : bsr_backup_ctrl
`default_nettype wire

// ### bsr_monitor.sv
`include "bsr_defines.svh"
`default_nettype none
module bsr_monitor (
  // Clock and reset
  input wire logic       clk_in,
  input wire logic       rst_n_in,
  // Design inputs
  input wire logic       backup_above_trip_in,
  input wire logic       main_above_backup_in,
  input wire logic       cmd_valid_in,
  input wire logic       cmd_is_status_read_in,
  input wire logic       write_done_in,
  // Design outputs
  input wire logic       cmd_accept_out,
  input wire logic       spi_respond_out,
  input wire logic [7:0] status_byte_out,
  input wire logic       transfer_busy_flag_out,
  input wire logic       array_modified_out,
  input wire logic       automatic_backup_disable_bit_out,
  input wire logic       store_pulse_out,
  input wire logic       recall_pulse_out,
  input wire logic       main_supply_connect_out,
  input wire logic       hibernating_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  wire logic   busy = transfer_busy_flag_out;
  logic [15:0] run;
  // ---
  // Busy run length
  // ---
  always_ff @(posedge clk_in) begin
    run <= busy ? run + 16'h1 : 16'h0;
  end
  sequence s_pwr_up;
    $rose(backup_above_trip_in) && !busy;
  endsequence
  sequence s_low;
    !backup_above_trip_in [*4];
  endsequence
  AST_ASD_RESET: assert property ($rose(rst_n_in) |-> !automatic_backup_disable_bit_out)
    else $error("disable bit set after reset");
  AST_BUSY_LEN: assert property ($fell(busy) |-> run == `BSR_STORE_CYC
    || run == `BSR_RESTORE_CYC || !backup_above_trip_in) else $error("busy length");
  AST_REFUSE: assert property (busy && cmd_valid_in && !cmd_is_status_read_in
    |-> !cmd_accept_out) else $error("command taken while busy");
  AST_POLL: assert property (busy && cmd_valid_in && cmd_is_status_read_in
    && spi_respond_out |-> cmd_accept_out) else $error("status read refused");
  AST_STATUS_BUSY: assert property (status_byte_out[0] == $past(busy))
    else $error("status busy bit");
  AST_MOD_SET: assert property (write_done_in && !busy && !hibernating_out
    && backup_above_trip_in |=> array_modified_out) else $error("modified not set");
  AST_MOD_CLR: assert property (store_pulse_out || recall_pulse_out
    |-> ##[0:1] !array_modified_out) else $error("modified not cleared");
  AST_SILENT: assert property (s_low |-> !spi_respond_out && !cmd_accept_out)
    else $error("answer below trip");
  AST_MAIN_OFF: assert property (!main_above_backup_in [*4]
    |-> !$rose(main_supply_connect_out)) else $error("main reconnected");
  AST_RECALL_UP: assert property (s_pwr_up |-> ##[2:8] busy)
    else $error("no recall on power-up");
  AST_NO_RECALL: assert property (store_pulse_out && backup_above_trip_in
    |=> !busy [*8]) else $error("recall after store");
endmodule : bsr_monitor
bind bsr_backup_ctrl bsr_monitor bsr_monitor_i (.*);
`default_nettype wire

// ### bsr_host_model.sv
`default_nettype none
module bsr_host_model (
  // Clock and answer
  input  wire logic clk_in,
  input  wire logic cmd_accept_out,
  // Frame and command
  output var logic  cs_n_in,
  output var logic  sck_in,
  output var logic  cmd_valid_in,
  output var logic  cmd_is_status_read_in,
  output var logic  cmd_sw_store_in,
  output var logic  cmd_sw_recall_in,
  output var logic  cmd_hibernate_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic acc;
  initial begin
    {cs_n_in, sck_in, cmd_valid_in} = 3'h4;
    {cmd_is_status_read_in, cmd_sw_store_in, cmd_sw_recall_in, cmd_hibernate_in} = 4'h0;
  end
  // ---
  // One frame: 0 read, 1 store, 2 recall, 3 sleep, 4 other
  // ---
  // host frames and wake
  task automatic send(input logic [2:0] k);
    @(negedge clk_in) cs_n_in = 1'b0;
    repeat (8) begin
      #32 sck_in = 1'b1;
      #32 sck_in = 1'b0;
    end
    @(negedge clk_in);
    {cmd_hibernate_in, cmd_sw_recall_in, cmd_sw_store_in, cmd_is_status_read_in} = 4'h1 << k;
    cmd_valid_in = 1'b1;
    @(posedge clk_in) acc = cmd_accept_out;
    @(negedge clk_in) cmd_valid_in = 1'b0;
    {cmd_hibernate_in, cmd_sw_recall_in, cmd_sw_store_in, cmd_is_status_read_in} = 4'h0;
    cs_n_in = 1'b1;
  endtask : send
endmodule : bsr_host_model
`default_nettype wire

// ### testbench.sv
`include "bsr_defines.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in, rst_n_in, backup_above_trip_in, main_above_backup_in, cs_n_in, sck_in;
  logic cmd_valid_in, cmd_is_status_read_in, cmd_sw_store_in, cmd_sw_recall_in;
  logic cmd_hibernate_in, write_done_in, cfg_we_in, cfg_rollover_in, cfg_automatic_backup_disable_in;
  logic cmd_accept_out, spi_respond_out, transfer_busy_flag_out, array_modified_out;
  logic automatic_backup_disable_bit_out, rollover_mode_bit_out, store_pulse_out, recall_pulse_out;
  logic main_supply_connect_out, hibernating_out, sck_rise_out;
  logic [1:0] cfg_block_protect_in, block_protect_field_out;
  logic [7:0] status_byte_out;
  logic [3:0] cfg;
  int         seed = 86, fail_count = 0, check_count = 0;
  logic [15:0] len;
  logic [15:0] sck_count = 16'h0000;
  bsr_backup_ctrl bsr_backup_ctrl_i (.*);
  bsr_host_model  bsr_host_model_i (.*);
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  // Link clock rises seen by the design
  always @(posedge clk_in) begin
    if (sck_rise_out) sck_count <= sck_count + 16'h0001;
  end
  // ---
  // Helpers
  // ---
  task automatic chk(input string n, input logic [15:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop;
    if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  task automatic xfer(input int lim);
    len = 16'h0000;
    repeat (lim) if (transfer_busy_flag_out !== 1'b1) @(negedge clk_in);
    while (transfer_busy_flag_out === 1'b1 && len < 3000) begin
      len++;
      @(negedge clk_in);
    end
    if (len == 3000) begin
      fail_count++;
      report_and_stop();
    end
    @(negedge clk_in);
  endtask : xfer
  task automatic pwr(input logic v, input int lim);
    @(negedge clk_in) backup_above_trip_in = v;
    xfer(lim);
  endtask : pwr
  task automatic wr;
    @(negedge clk_in) write_done_in = 1'b1;
    @(negedge clk_in) write_done_in = 1'b0;
  endtask : wr
  task automatic setcfg(input logic [3:0] c);
    @(negedge clk_in) {cfg_block_protect_in, cfg_rollover_in, cfg_automatic_backup_disable_in} = c;
    cfg_we_in = 1'b1;
    @(negedge clk_in) cfg_we_in = 1'b0;
  endtask : setcfg
  task automatic probe(input int n);
    logic [15:0] base;
    for (int k = 0; k < n; k++) begin
      base = sck_count;
      bsr_host_model_i.send(3'(k));
      chk("busy_accept", bsr_host_model_i.acc, k == 0);
      chk("busy_bit", status_byte_out[0], 1'b1);
      chk("sck_rises", sck_count - base, 16'h0008);
    end
  endtask : probe
  // ---
  // Main sequence
  // ---
  initial begin
    {rst_n_in, backup_above_trip_in, main_above_backup_in, write_done_in} = 4'h0;
    {cfg_we_in, cfg_block_protect_in, cfg_rollover_in, cfg_automatic_backup_disable_in} = 5'h00;
    repeat (8) @(negedge clk_in);
    rst_n_in = 1'b1;
    @(negedge clk_in) chk("asd_reset", automatic_backup_disable_bit_out, 1'b0);
    main_above_backup_in = 1'b1;
    pwr(1'b1, 20);
    chk("recall_len", len, `BSR_RESTORE_CYC);
    repeat (3) begin
      cfg = 4'($random(seed));
      setcfg(cfg);
      fork xfer(200); begin bsr_host_model_i.send(3'h1); probe(5); end join
      chk("store_len", len, `BSR_STORE_CYC);
      chk("busy_clear", status_byte_out[0], 1'b0);
      setcfg(~cfg);
      fork xfer(200); begin bsr_host_model_i.send(3'h2); probe(3); end join
      chk("sw_recall_len", len, `BSR_RESTORE_CYC);
      chk("cfg_back", {block_protect_field_out, rollover_mode_bit_out,
          automatic_backup_disable_bit_out}, cfg);
      @(negedge clk_in);
      chk("status_cfg", {status_byte_out[3:2], status_byte_out[4], status_byte_out[6]}, cfg);
    end
    setcfg(4'h0);
    wr();
    chk("modified", array_modified_out, 1'b1);
    main_above_backup_in = 1'b0;
    fork
      pwr(1'b0, 20);
      begin
        repeat (100) @(negedge clk_in);
        chk("main_off", main_supply_connect_out, 1'b0);
        {backup_above_trip_in, main_above_backup_in} = 2'h3;
        bsr_host_model_i.send(3'h0);
        chk("auto_store_refuse", bsr_host_model_i.acc, 1'b0);
      end
    join
    chk("auto_store_len", len, `BSR_STORE_CYC);
    @(negedge clk_in) chk("main_back", main_supply_connect_out, 1'b1);
    xfer(30);
    chk("no_recall", len, 0);
    pwr(1'b0, 30);
    chk("unmodified_no_store", len, 0);
    fork
      pwr(1'b1, 20);
      begin
        repeat (60) @(negedge clk_in);
        backup_above_trip_in = 1'b0;
      end
    join
    chk("recall_abort", len > 40 && len < 70, 1'b1);
    xfer(30);
    chk("abort_no_store", len, 0);
    pwr(1'b1, 20);
    setcfg(4'h1);
    wr();
    pwr(1'b0, 30);
    chk("asd_no_store", len, 0);
    pwr(1'b1, 20);
    chk("asd_recall", len, `BSR_RESTORE_CYC);
    wr();
    bsr_host_model_i.send(3'h3);
    xfer(30);
    chk("hib_store", len, `BSR_STORE_CYC);
    repeat (20) @(negedge clk_in);
    chk("asleep", hibernating_out, 1'b1);
    fork xfer(200); bsr_host_model_i.send(3'h0); join
    chk("wake_len", len, `BSR_RESTORE_CYC);
    chk("awake", hibernating_out, 1'b0);
    chk("wake_poll", bsr_host_model_i.acc, 1'b1);
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
